// File: hdl/codec_link_bank.sv
// codec link register bank: link receiver/transmitter, ram bank and shadow bits
`timescale 1ns/1ps
`include "codec_link_cfg.svh"

// Notes on behaviour
// - reads return the stored ram word unless a special case applies.
// - extended audio and modem id registers read bit 14 from select pin, bit 15 as zero.
// - the dsp never sees the select pin level.
// - link power-down bit drives bit clock and input data low.
// - warm reset clears the link power-down bit to zero.
// - reading the power-down bit returns the live shadow, not ram.
// - rate control reads give bb80h or ac44h from one flag.
// - every rate control write updates the rate flag.
// - full-compliant read mode is the default.
// - full-compliant mode zeroes reserved bits of power-down register reads only.
// - with compliance off, power-down reads return reserved bits 7:4 from ram.
// - odd address reads reply with slots 1, 2 valid, address, zeros.
// - writes store the full sixteen-bit word, reserved bits too.
// - writes update shadow bits together with the ram copy.
// - reset or write to 00h returns shadows to defaults; dsp restores ram.
// - writes to either vendor identity register are discarded.
// - writes to the extended audio identity register are discarded.
// - power-down writes store upper twelve bits, low four forced 1110.
// - extended audio control writes force a 0111 field.
// - converter rate writes always store bb80h.
module codec_link_bank
    import codec_link_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        bit_clk,
    input  wire logic        sync_pin,
    input  wire logic        sdata_out_pin,
    input  wire logic        address_select_pin,
    input  wire logic        dsp_req,
    input  wire logic        dsp_we,
    input  wire logic [6:0]  dsp_addr,
    input  wire logic [15:0] dsp_wdata,
    output logic             sdata_in,
    output logic             bit_clk_force_low,
    output logic [15:0]      dsp_rdata,
    output logic             dsp_ack
);
    core_state_t c_q;
    core_state_t c_d;
    link_state_t l_q;
    link_state_t l_d;
    logic        lrs1;
    logic        lrs2;
    logic        ram_we;
    logic [5:0]  ram_addr;
    logic [15:0] ram_wdata;
    logic [15:0] ram_rdata;
    logic [7:0]  idx;
    logic [19:0] nsh;
    logic [55:0] load;
    logic        lw_take;
    logic        lr_take;

    function automatic logic is_rate(input logic [6:0] a);
        return a == `REG_RATE_A || a == `REG_RATE_B || a == `REG_RATE_C;
    endfunction

    function automatic logic wr_ignored(input logic [6:0] a);
        return a == `REG_VEND_ONE || a == `REG_VEND_TWO || a == `REG_EXT_ID;
    endfunction

    function automatic logic [15:0] wr_value(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] v;
        v = d;
        if (a == `REG_PWR_CTL) begin
            v[3:0] = `PWR_LOW_NIBBLE;
        end
        if (a == `REG_EXT_CTL) begin
            v[`EXT_CTL_LSB +: 4] = `EXT_CTL_FIELD;
        end
        if (a == `REG_CONV_A || a == `REG_CONV_B) begin
            v = `RATE_48K;
        end
        return v;
    endfunction

    function automatic logic [15:0] rd_value(input logic [6:0] a, input logic [15:0] r,
                                            input core_state_t s);
        logic [15:0] v;
        v = r;
        if (s.fc && a <= `REG_STD_TOP && a == `REG_PWR_CTL) begin
            v = v & `MASK_PWR_CTL;
        end
        if (a == `REG_EXT_ID || a == `REG_MODEM_ID) begin
            v[`ID_ZERO_BIT]   = 1'b0;
            v[`ID_SELECT_BIT] = s.asel2;
        end
        if (a == `REG_PWR_CTL) begin
            v[`PWR_LINK_BIT] = s.pd;
        end
        if (is_rate(a)) begin
            v = s.rate ? `RATE_44K : `RATE_48K;
        end
        return v;
    endfunction

    codec_reg_ram #(
        .AW(6),
        .DW(16)
    ) u_ram (
        .clk   (core_clk),
        .we    (ram_we),
        .addr  (ram_addr),
        .wdata (ram_wdata),
        .rdata (ram_rdata)
    );

    assign lw_take = c_q.st == ST_IDLE && c_q.rq_pend && !l_q.rw;
    assign lr_take = c_q.st == ST_IDLE && c_q.rq_pend && l_q.rw;

    // core domain
    always_comb begin
        c_d       = c_q;
        ram_we    = 1'b0;
        ram_addr  = 6'h00;
        ram_wdata = 16'h0000;
        c_d.asel1 = address_select_pin;
        c_d.asel2 = c_q.asel1;
        c_d.sy1   = sync_pin;
        c_d.sy2   = c_q.sy1;
        c_d.rq1   = l_q.req_tgl;
        c_d.rq2   = c_q.rq1;
        c_d.rq3   = c_q.rq2;
        c_d.ack   = 1'b0;
        if (c_q.rq2 ^ c_q.rq3) begin
            c_d.rq_pend = 1'b1;
        end
        // warm reset: sync held high while the link sleeps
        if (c_q.pd && c_q.sy2) begin
            if (c_q.warm_cnt == 8'(`WARM_CYC - 1)) begin
                c_d.pd       = `PD_RESET;
                c_d.warm_cnt = 8'h00;
            end else begin
                c_d.warm_cnt = c_q.warm_cnt + 8'h01;
            end
        end else begin
            c_d.warm_cnt = 8'h00;
        end
        case (c_q.st)
            ST_IDLE: begin
                if (c_q.rq_pend) begin
                    // a new edge in the same cycle keeps the request pending
                    c_d.rq_pend  = c_q.rq2 ^ c_q.rq3;
                    c_d.cur_addr = l_q.addr;
                    ram_addr     = l_q.addr[6:1];
                    if (!l_q.rw) begin
                        ram_we    = !wr_ignored(l_q.addr);
                        ram_wdata = wr_value(l_q.addr, l_q.data);
                        if (l_q.addr == `REG_PWR_CTL) begin
                            c_d.pd = l_q.data[`PWR_LINK_BIT];
                        end
                        if (is_rate(l_q.addr)) begin
                            c_d.rate = l_q.data == `RATE_44K;
                        end
                        if (l_q.addr == `REG_CONFIG) begin
                            c_d.fc = l_q.data[`CFG_FC_BIT];
                        end
                        if (l_q.addr == `REG_LINK_RESET) begin
                            c_d.pd   = `PD_RESET;
                            c_d.rate = 1'b0;
                            c_d.fc   = `FC_RESET;
                        end
                    end else if (l_q.addr[0]) begin
                        c_d.rep_addr = l_q.addr;
                        c_d.rep_data = 16'h0000;
                        c_d.rep_tgl  = !c_q.rep_tgl;
                    end else begin
                        c_d.st = ST_LINK_RD;
                    end
                end else if (dsp_req && !c_q.ack) begin
                    ram_addr = dsp_addr[6:1];
                    if (dsp_we) begin
                        // dsp writes go straight in so it can restore defaults
                        ram_we    = 1'b1;
                        ram_wdata = dsp_wdata;
                        c_d.ack   = 1'b1;
                    end else begin
                        c_d.st = ST_DSP_RD;
                    end
                end
            end
            ST_LINK_RD: begin
                c_d.rep_addr = c_q.cur_addr;
                c_d.rep_data = rd_value(c_q.cur_addr, ram_rdata, c_q);
                c_d.rep_tgl  = !c_q.rep_tgl;
                c_d.st       = ST_IDLE;
            end
            ST_DSP_RD: begin
                c_d.rdata = ram_rdata;
                c_d.ack   = 1'b1;
                c_d.st    = ST_IDLE;
            end
            default: begin
                c_d.st = ST_IDLE;
            end
        endcase
        c_d.clk_low = c_d.pd;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            c_q    <= '0;
            c_q.fc <= `FC_RESET;
            c_q.pd <= `PD_RESET;
        end else begin
            c_q <= c_d;
        end
    end

    assign bit_clk_force_low = c_q.clk_low;
    assign dsp_rdata         = c_q.rdata;
    assign dsp_ack           = c_q.ack;

    // link reset taken from the core reset through two stages
    always_ff @(posedge bit_clk) begin
        lrs1 <= sys_rst;
        lrs2 <= lrs1;
    end

    // link domain; bit index 0 is the first bit after sync rises
    always_comb begin
        l_d     = l_q;
        l_d.sy1 = sync_pin;
        l_d.sy2 = l_q.sy1;
        l_d.sy3 = l_q.sy2;
        l_d.sd1 = sdata_out_pin;
        l_d.sd2 = l_q.sd1;
        l_d.pd1 = c_q.clk_low;
        l_d.pd2 = l_q.pd1;
        l_d.rt1 = c_q.rep_tgl;
        l_d.rt2 = l_q.rt1;
        l_d.rt3 = l_q.rt2;
        idx     = (l_q.sy2 && !l_q.sy3) ? 8'h00 : l_q.cnt;
        l_d.cnt = (idx == 8'hff) ? idx : idx + 8'h01;
        nsh     = {l_q.shin[18:0], l_q.sd2};
        l_d.shin = nsh;
        if (idx == `SLOT0_END) begin
            l_d.cmd_ok = nsh[14];
            l_d.dat_ok = nsh[13];
        end
        if (idx == `SLOT1_END && l_q.cmd_ok) begin
            l_d.rw   = nsh[19];
            l_d.addr = nsh[18:12];
        end
        if (idx == `SLOT2_END && l_q.cmd_ok && (l_q.rw || l_q.dat_ok)) begin
            l_d.data    = nsh[19:4];
            l_d.req_tgl = !l_q.req_tgl;
        end
        load = {1'b1, l_q.pend, l_q.pend, 13'h0000, 1'b0, l_q.rp_addr, 12'h000,
                l_q.rp_data, 4'h0};
        if (idx == 8'h00) begin
            l_d.sdo  = load[55];
            l_d.tx   = {load[54:0], 1'b0};
            l_d.pend = 1'b0;
        end else begin
            l_d.sdo = l_q.tx[55];
            l_d.tx  = {l_q.tx[54:0], 1'b0};
        end
        // reply lands after the load so a late arrival waits a frame
        if (l_q.rt2 ^ l_q.rt3) begin
            l_d.pend    = 1'b1;
            l_d.rp_addr = c_q.rep_addr;
            l_d.rp_data = c_q.rep_data;
        end
        if (l_q.pd2) begin
            l_d.sdo = 1'b0;
        end
    end

    always_ff @(posedge bit_clk) begin
        if (lrs2) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    assign sdata_in = l_q.sdo;

    sequence rate_write_44k;
        lw_take && is_rate(l_q.addr) && l_q.data == `RATE_44K;
    endsequence

    sequence even_read_of(logic [6:0] a);
        lr_take && l_q.addr == a ##1 c_q.st == ST_LINK_RD;
    endsequence

    pd_clock_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        lw_take && l_q.addr == `REG_PWR_CTL && l_q.data[`PWR_LINK_BIT] |=> bit_clk_force_low)
        else $error("bit clock not forced low while powered down");

    pd_data_low_a: assert property (@(posedge bit_clk) disable iff (lrs2)
        l_q.pd2 |=> !sdata_in)
        else $error("input data not low while powered down");

    warm_clear_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        c_q.pd && c_q.sy2 && c_q.warm_cnt == 8'(`WARM_CYC - 1) |=> !c_q.pd)
        else $error("warm reset did not clear power-down");

    pd_readback_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        even_read_of(`REG_PWR_CTL) |=> c_q.rep_data[`PWR_LINK_BIT] == $past(c_q.pd))
        else $error("power-down readback not live");

    rate_flag_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        rate_write_44k |=> c_q.rate)
        else $error("rate flag not set by 44.1 khz write");

    rate_read_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        even_read_of(`REG_RATE_B) |=>
        c_q.rep_data == ($past(c_q.rate) ? `RATE_44K : `RATE_48K))
        else $error("rate control readback wrong");

    id_select_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        even_read_of(`REG_EXT_ID) |=>
        !c_q.rep_data[`ID_ZERO_BIT] && c_q.rep_data[`ID_SELECT_BIT] == $past(c_q.asel2))
        else $error("identity codec bits wrong");

    odd_reply_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        lr_take && l_q.addr[0] |=> c_q.rep_data == 16'h0000 && c_q.rep_addr[0]
        && c_q.rep_tgl != $past(c_q.rep_tgl))
        else $error("odd read reply wrong");

    id_write_drop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        lw_take && wr_ignored(l_q.addr) |-> !ram_we)
        else $error("write to read-only register stored");

    pwr_nibble_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        lw_take && l_q.addr == `REG_PWR_CTL |->
        ram_we && ram_wdata == {l_q.data[15:4], `PWR_LOW_NIBBLE})
        else $error("power-down write value wrong");

    conv_fixed_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        lw_take && (l_q.addr == `REG_CONV_A || l_q.addr == `REG_CONV_B) |->
        ram_wdata == `RATE_48K)
        else $error("converter rate write not fixed");

    soft_reset_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        lw_take && l_q.addr == `REG_LINK_RESET |=> c_q.fc && !c_q.rate ##1 !c_q.clk_low)
        else $error("soft reset left shadows set");
endmodule

// File: hdl/codec_link_cfg.svh
// offsets, field positions, reset values and timing of the codec link register bank
`ifndef CODEC_LINK_CFG_SVH
`define CODEC_LINK_CFG_SVH

`define REG_LINK_RESET   7'h00
`define REG_PWR_CTL      7'h26
`define REG_EXT_ID       7'h28
`define REG_EXT_CTL      7'h2a
`define REG_RATE_A       7'h2c
`define REG_RATE_B       7'h2e
`define REG_RATE_C       7'h30
`define REG_CONV_A       7'h32
`define REG_CONV_B       7'h34
`define REG_MODEM_ID     7'h3c
`define REG_CONFIG       7'h5a
`define REG_VEND_ONE     7'h7c
`define REG_VEND_TWO     7'h7e
`define REG_STD_TOP      7'h58

`define PWR_LINK_BIT     12
`define PWR_LOW_NIBBLE   4'he
`define ID_SELECT_BIT    14
`define ID_ZERO_BIT      15
`define EXT_CTL_LSB      7
`define EXT_CTL_FIELD    4'h7
`define CFG_FC_BIT       0
`define MASK_PWR_CTL     16'hff0f

`define RATE_48K         16'hbb80
`define RATE_44K         16'hac44
`define FC_RESET         1'b1
`define PD_RESET         1'b0

`define SLOT0_END        8'd15
`define SLOT1_END        8'd35
`define SLOT2_END        8'd55

`define CLK_NS           40
`define WARM_NS          1000
`define WARM_CYC         ((`WARM_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// File: hdl/codec_link_pkg.sv
// types shared by the codec link register bank
package codec_link_pkg;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_LINK_RD = 2'b01,
        ST_DSP_RD  = 2'b10
    } bank_state_t;

    typedef struct packed {
        logic        sy1;
        logic        sy2;
        logic        sy3;
        logic        sd1;
        logic        sd2;
        logic        pd1;
        logic        pd2;
        logic        rt1;
        logic        rt2;
        logic        rt3;
        logic [7:0]  cnt;
        logic [19:0] shin;
        logic        cmd_ok;
        logic        dat_ok;
        logic        rw;
        logic [6:0]  addr;
        logic [15:0] data;
        logic        req_tgl;
        logic        pend;
        logic [6:0]  rp_addr;
        logic [15:0] rp_data;
        logic [55:0] tx;
        logic        sdo;
    } link_state_t;

    typedef struct packed {
        logic        asel1;
        logic        asel2;
        logic        sy1;
        logic        sy2;
        logic        rq1;
        logic        rq2;
        logic        rq3;
        logic        rq_pend;
        bank_state_t st;
        logic [7:0]  warm_cnt;
        logic        pd;
        logic        rate;
        logic        fc;
        logic [6:0]  cur_addr;
        logic [6:0]  rep_addr;
        logic [15:0] rep_data;
        logic        rep_tgl;
        logic        ack;
        logic [15:0] rdata;
        logic        clk_low;
    } core_state_t;

endpackage

// File: hdl/codec_reg_ram.sv
// shared register ram with registered read data
`timescale 1ns/1ps
module codec_reg_ram #(
    parameter int AW = 6,
    parameter int DW = 16
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // no reset: contents are restored by the dsp, not by hardware
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// File: sim/ac_link_ctl.sv
// behavioural link controller: sends command frames, captures the reply stream
`timescale 1ns/1ps
module ac_link_ctl (
    input  wire logic bit_clk,
    input  wire logic sdata_in,
    output logic      sync_pin,
    output logic      sdata_out_pin
);
    logic [0:79] cap;
    logic        rep_any;
    logic        rep_ready;
    logic [1:0]  rep_tag;
    logic [6:0]  rep_addr;
    logic [15:0] rep_data;

    initial begin
        sync_pin      = 1'b0;
        sdata_out_pin = 1'b0;
    end

    // one 80-bit frame, slots 0..2 msb first, unused slots stuffed with zeros
    task automatic frame(input logic cmd, input logic rd, input logic [6:0] a,
                         input logic [15:0] d);
        logic [55:0] word;
        int          off;
        word = {1'b1, cmd, cmd & ~rd, 13'h0, rd, a, 12'h0, rd ? 16'h0 : d, 4'h0};
        for (int i = 0; i < 80; i++) begin
            @(posedge bit_clk);
            sync_pin      <= (i < 16);
            sdata_out_pin <= (i < 56) ? word[55 - i] : 1'b0;
            @(negedge bit_clk);
            cap[i] = sdata_in;
        end
        // reply lags by a few bit clocks; the ready bit marks its start
        off = 0;
        for (int i = 11; i >= 0; i--) begin
            if (cap[i] === 1'b1) off = i;
        end
        rep_any   = |cap;
        rep_ready = cap[off];
        rep_tag   = {cap[off + 1], cap[off + 2]};
        rep_addr  = cap[off + 17 +: 7];
        rep_data  = cap[off + 36 +: 16];
    endtask

    // sync held high well past a microsecond, data line quiet
    task automatic warm();
        @(posedge bit_clk);
        sync_pin      <= 1'b1;
        sdata_out_pin <= 1'b0;
        repeat (30) @(posedge bit_clk);
        sync_pin <= 1'b0;
        repeat (8) @(posedge bit_clk);
    endtask
endmodule

// File: sim/tb.sv
// self-checking bench for the codec link register bank
`timescale 1ns/1ps
module tb;
    import codec_link_pkg::*;
    logic        core_clk;
    logic        sys_rst;
    logic        bit_clk;
    logic        sync_pin;
    logic        sdata_out_pin;
    logic        address_select_pin;
    logic        dsp_req;
    logic        dsp_we;
    logic [6:0]  dsp_addr;
    logic [15:0] dsp_wdata;
    logic        sdata_in;
    logic        bit_clk_force_low;
    logic [15:0] dsp_rdata;
    logic        dsp_ack;
    int          fails;
    int          comparisons;
    int          cycles;

    codec_link_bank codec_link_bank_i (
        .core_clk           (core_clk),
        .sys_rst            (sys_rst),
        .bit_clk            (bit_clk),
        .sync_pin           (sync_pin),
        .sdata_out_pin      (sdata_out_pin),
        .address_select_pin (address_select_pin),
        .dsp_req            (dsp_req),
        .dsp_we             (dsp_we),
        .dsp_addr           (dsp_addr),
        .dsp_wdata          (dsp_wdata),
        .sdata_in           (sdata_in),
        .bit_clk_force_low  (bit_clk_force_low),
        .dsp_rdata          (dsp_rdata),
        .dsp_ack            (dsp_ack)
    );

    ac_link_ctl ac_link_ctl_i (
        .bit_clk       (bit_clk),
        .sdata_in      (sdata_in),
        .sync_pin      (sync_pin),
        .sdata_out_pin (sdata_out_pin)
    );

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    // phase offset keeps the two domains unrelated
    initial begin
        bit_clk = 1'b0;
        #7;
        forever #24 bit_clk = ~bit_clk;
    end

    task automatic tally_and_finish();
        if (fails == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // request held until ack is sampled high, read data taken at that edge
    task automatic dsp_op(input logic we, input logic [6:0] a, input logic [15:0] d);
        int n;
        @(posedge core_clk);
        dsp_req   <= 1'b1;
        dsp_we    <= we;
        dsp_addr  <= a;
        dsp_wdata <= d;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (dsp_ack !== 1'b1 && n < 20);
        check("dsp ack", {15'h0, dsp_ack}, 16'h0001);
        if (!we) begin
            check("dsp read", dsp_rdata, d);
        end
        dsp_req <= 1'b0;
    endtask

    task automatic link_write(input logic [6:0] a, input logic [15:0] d);
        ac_link_ctl_i.frame(1'b1, 1'b0, a, d);
    endtask

    // command frame, then an empty frame that carries the reply
    task automatic link_read(input logic [6:0] a, input logic [15:0] exp);
        ac_link_ctl_i.frame(1'b1, 1'b1, a, 16'h0);
        ac_link_ctl_i.frame(1'b0, 1'b0, 7'h00, 16'h0);
        check("reply tags", {13'h0, ac_link_ctl_i.rep_ready, ac_link_ctl_i.rep_tag}, 16'h0007);
        check("reply addr", {9'h0, ac_link_ctl_i.rep_addr}, {9'h0, a});
        check("reply data", ac_link_ctl_i.rep_data, exp);
    endtask

    task automatic t_raw();
        dsp_op(1'b1, 7'h12, 16'ha5c3);
        link_read(7'h12, 16'ha5c3);
        link_write(7'h14, 16'hffff);
        dsp_op(1'b0, 7'h14, 16'hffff);
    endtask

    task automatic t_ident();
        dsp_op(1'b1, 7'h28, 16'hffff);
        dsp_op(1'b1, 7'h3c, 16'hc123);
        address_select_pin <= 1'b1;
        link_read(7'h28, 16'h7fff);
        @(posedge core_clk);
        address_select_pin <= 1'b0;
        link_read(7'h3c, 16'h0123);
        dsp_op(1'b0, 7'h28, 16'hffff);
    endtask

    task automatic t_read_only();
        dsp_op(1'b1, 7'h7c, 16'hbeef);
        dsp_op(1'b1, 7'h7e, 16'h4a11);
        link_write(7'h28, 16'h0000);
        link_write(7'h7c, 16'h1111);
        link_write(7'h7e, 16'h2222);
        dsp_op(1'b0, 7'h28, 16'hffff);
        dsp_op(1'b0, 7'h7c, 16'hbeef);
        dsp_op(1'b0, 7'h7e, 16'h4a11);
    endtask

    task automatic t_forced();
        link_write(7'h2a, 16'hffff);
        dsp_op(1'b0, 7'h2a, 16'hfbff);
        link_write(7'h2a, 16'h0000);
        dsp_op(1'b0, 7'h2a, 16'h0380);
        link_write(7'h32, 16'h1234);
        dsp_op(1'b0, 7'h32, 16'hbb80);
        link_write(7'h34, 16'h0000);
        dsp_op(1'b0, 7'h34, 16'hbb80);
    endtask

    task automatic t_rate();
        link_read(7'h2c, 16'hbb80);
        link_write(7'h2e, 16'hac44);
        link_read(7'h2c, 16'hac44);
        link_read(7'h30, 16'hac44);
        link_write(7'h30, 16'h5622);
        link_read(7'h2e, 16'hbb80);
        link_read(7'h2d, 16'h0000);
    endtask

    task automatic t_power();
        link_write(7'h26, 16'h10f5);
        dsp_op(1'b0, 7'h26, 16'h10fe);
        check("force low", {15'h0, bit_clk_force_low}, 16'h0001);
        ac_link_ctl_i.frame(1'b0, 1'b0, 7'h00, 16'h0);
        check("quiet reply", {15'h0, ac_link_ctl_i.rep_any}, 16'h0000);
        ac_link_ctl_i.warm();
        repeat (4) @(posedge core_clk);
        check("force low", {15'h0, bit_clk_force_low}, 16'h0000);
        link_read(7'h26, 16'h000e);
        link_write(7'h5a, 16'h0000);
        link_read(7'h26, 16'h00fe);
        link_write(7'h2e, 16'hac44);
        link_write(7'h26, 16'h1000);
        link_write(7'h00, 16'h0000);
        check("force low", {15'h0, bit_clk_force_low}, 16'h0000);
        link_read(7'h26, 16'h000e);
        link_read(7'h2c, 16'hbb80);
        dsp_op(1'b1, 7'h26, 16'h0000);
        dsp_op(1'b0, 7'h26, 16'h0000);
    endtask

    initial begin
        sys_rst            = 1'b1;
        address_select_pin = 1'b0;
        dsp_req            = 1'b0;
        dsp_we             = 1'b0;
        dsp_addr           = 7'h00;
        dsp_wdata          = 16'h0000;
        fails              = 0;
        comparisons        = 0;
        cycles             = 0;
        repeat (4) @(posedge core_clk);
        sys_rst <= 1'b0;
        // link reset trails by a few bit clocks
        repeat (6) @(posedge core_clk);
        t_raw();
        t_ident();
        t_read_only();
        t_forced();
        t_rate();
        t_power();
        tally_and_finish();
    end
endmodule
